// ==== src/pmr_consts.vh ====
/*
 * Constants for the pack monitor register access block: byte addresses,
 * field positions, reset values and non-volatile memory geometry.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PMR_CONSTS_VH
`define PMR_CONSTS_VH

// ********************************************************
// Address map
// ********************************************************
`define PMR_AW            8
`define PMR_DW            8
`define PMR_NV_LAST       8'h7F
`define PMR_RSV1_LO       8'h4C
`define PMR_RSV1_HI       8'h4F
`define PMR_RSV2_LO       8'h58
`define PMR_RSV2_HI       8'h7F
`define PMR_RSV3_LO       8'hAC
`define PMR_ADDR_STATUS   8'h80
`define PMR_ADDR_FETCTL   8'h86
`define PMR_ADDR_CTL      8'h88
`define PMR_ADDR_NVEN     8'h89
`define PMR_ADDR_ADC_LO   8'hAA
`define PMR_ADDR_ADC_HI   8'hAB

// ********************************************************
// Field positions and masks
// ********************************************************
`define PMR_FET_DSG       0
`define PMR_FET_CHG       1
`define PMR_FET_MASK      8'h03
`define PMR_CTL_OVR       0
`define PMR_CTL_SCANOFF   1
`define PMR_CTL_WDCTL     2
`define PMR_CTL_MASK      8'h07
`define PMR_NVEN_SEL      0
`define PMR_NVEN_MASK     8'h01
`define PMR_ST_SLEEP      0
`define PMR_ST_FAULT      1
`define PMR_ST_OFF        2
`define PMR_ADC_HI_MASK   8'h3F

// ********************************************************
// Reset values and geometry
// ********************************************************
`define PMR_RST_ZERO      8'h00
`define PMR_NV_PAGES      8
`define PMR_NV_PAGE_BYTES 16
`define PMR_NV_WORDS      128
`define PMR_NV_IDX_W      7
`define PMR_PG_IDX_W      4
`define PMR_NV_WR_NS      5000
`define PMR_CLK_NS        8

`endif

// ==== src/pmr_nv_array.v ====
/*
 * Non-volatile array model: eight pages of sixteen bytes with a page
 * write that commits a collected page in one program cycle.
 * Assumes the caller writes bytes of a single page and holds off accesses while busy.
 */
`timescale 1ns/1ps
`include "pmr_consts.vh"

module pmr_nv_array (
    input  wire                       ref_clk,
    input  wire                       reset,
    input  wire [`PMR_NV_IDX_W-1:0]   rd_addr,
    output wire [`PMR_DW-1:0]         rd_data,
    input  wire                       byte_we,
    input  wire [`PMR_NV_IDX_W-1:0]   byte_addr,
    input  wire [`PMR_DW-1:0]         byte_data,
    input  wire                       page_commit,
    output reg                        busy_q
);
    localparam integer PROG_CYC = (`PMR_NV_WR_NS + `PMR_CLK_NS - 1) / `PMR_CLK_NS;

    reg [`PMR_DW-1:0]  mem_q [0:`PMR_NV_WORDS-1];
    reg [`PMR_DW-1:0]  pbuf_q [0:`PMR_NV_PAGE_BYTES-1];
    reg [`PMR_NV_PAGE_BYTES-1:0] pdirty_q;
    reg [2:0]          page_q;
    reg [12:0]         cnt_q;
    integer            i;

    assign rd_data = mem_q[rd_addr];

    // Bytes of one page collect here, then program together. [R13]
    always @(posedge ref_clk) begin
        if (reset) begin
            pdirty_q <= {`PMR_NV_PAGE_BYTES{1'b0}};
            busy_q   <= 1'b0;
            cnt_q    <= 13'h0000;
            page_q   <= 3'h0;
        end else if (busy_q) begin
            if (cnt_q == 13'h0000) begin
                for (i = 0; i < `PMR_NV_PAGE_BYTES; i = i + 1) begin
                    if (pdirty_q[i])
                        mem_q[{page_q, i[3:0]}] <= pbuf_q[i];
                end
                pdirty_q <= {`PMR_NV_PAGE_BYTES{1'b0}};
                busy_q   <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 13'h0001;
            end
        end else begin
            if (byte_we) begin
                pbuf_q[byte_addr[3:0]]   <= byte_data;
                pdirty_q[byte_addr[3:0]] <= 1'b1;
                page_q                   <= byte_addr[6:4];
            end
            // The commit strobe always comes with a byte write, so a one-byte page
            // write still programs even though no byte was dirty before it.
            if (page_commit) begin
                busy_q <= 1'b1;
                cnt_q  <= PROG_CYC[12:0];
            end
        end
    end
endmodule

// ==== src/pmr_fet_ctrl.v ====
/*
 * Power switch drive decision: automatic protection or host override,
 * with hard faults and sleep always forcing the switches off.
 * Assumes fault and request inputs are synchronous to ref_clk.
 */
`timescale 1ns/1ps
`include "pmr_consts.vh"

module pmr_fet_ctrl (
    input  wire       ref_clk,
    input  wire       reset,
    input  wire       host_switch_override,
    input  wire [1:0] host_req,
    input  wire [1:0] auto_req,
    input  wire       hard_fault,
    input  wire       sleep_flag,
    input  wire       all_switches_off,
    output reg  [1:0] drive_q
);
    reg [1:0] drive_d;

    always @* begin
        if (host_switch_override)
            drive_d = host_req;  // [R8]
        else
            drive_d = auto_req;  // [R7]
        if (hard_fault || sleep_flag || all_switches_off)
            drive_d = 2'h0;      // [R16]
    end

    always @(posedge ref_clk) begin
        if (reset)
            drive_q <= 2'h0;
        else
            drive_q <= drive_d;
    end
endmodule

// ==== src/pmr_regs.v ====
/*
 * Register bank of the pack monitor as seen by the host over I2C: shadow
 * and non-volatile configuration area, switch control, control bits,
 * status flags and the raw conversion result.
 * Assumes an I2C slave upstream that gives one-cycle read and write
 * strobes with a byte address, and reads rd_data the cycle after.
 */
// How it works
// R1: Written ones trigger their control action.
// R2: Status bits read one while condition exists.
// R3: Host writes reserved bits as zero.
// R4: Host never writes reserved address ranges.
// R5: Host ignores reserved bits on read.
// R6: Sleep cleared: power-up, charger rise, load fall.
// R7: Automatic mode: hardware drives switch bits.
// R8: Override: host drives switches, read shows drive.
// R9: Select zero routes area to shadow.
// R10: Select one routes area to array.
// R11: Host sets select alone before programming.
// R12: Watchdog expiry clears governed control bit.
// R13: Array is eight pages of sixteen bytes.
// R14: Scan disable stops all measurement scans.
// R15: Host handles protection while scans off.
// R16: Faults, sleep, all-off force switches off.
// R17: Reserved writes ignored, nothing else changes.
`timescale 1ns/1ps
`include "pmr_consts.vh"

module pmr_regs (
    input  wire                 ref_clk,
    input  wire                 reset,
    input  wire                 wr_stb,
    input  wire                 rd_stb,
    input  wire [`PMR_AW-1:0]   addr,
    input  wire [`PMR_DW-1:0]   wr_data,
    input  wire                 wr_last,
    output reg  [`PMR_DW-1:0]   rd_data_q,
    output reg                  nv_busy_q,
    input  wire                 charger_monitor_input,
    input  wire                 load_monitor_input,
    input  wire                 sleep_entry,
    input  wire [1:0]           auto_req,
    input  wire                 short_circuit,
    input  wire                 open_wire,
    input  wire                 internal_over_temp,
    input  wire                 overvoltage_lockout,
    input  wire                 undervoltage_lockout,
    input  wire                 all_switches_off,
    input  wire                 watchdog_expired,
    input  wire                 watchdog_active,
    input  wire [13:0]          conversion_value,
    input  wire                 conversion_valid,
    output reg  [1:0]           switch_drive_q,
    output reg                  scan_enable_q,
    output reg                  wd_ctl_q
);
    // ********************************************************
    // Address decode helpers
    // ********************************************************
    function is_reserved;
        input [`PMR_AW-1:0] a;
        begin
            is_reserved = ((a >= `PMR_RSV1_LO) && (a <= `PMR_RSV1_HI)) ||
                          ((a >= `PMR_RSV2_LO) && (a <= `PMR_RSV2_HI)) ||
                          (a >= `PMR_RSV3_LO);
        end
    endfunction

    function is_nv;
        input [`PMR_AW-1:0] a;
        begin
            is_nv = (a <= `PMR_NV_LAST) && !is_reserved(a);
        end
    endfunction

    // ********************************************************
    // State
    // ********************************************************
    reg [`PMR_DW-1:0] shadow_q [0:`PMR_NV_WORDS-1];
    reg [1:0]         host_fet_q;
    reg               override_q;
    reg               scan_off_q;
    reg               nv_sel_q;
    reg               sleep_q;
    reg               chg_mon_q;
    reg               ld_mon_q;
    reg               pwr_up_q;
    reg [13:0]        adc_q;
    reg [`PMR_DW-1:0] rd_d;
    wire [1:0]        drive_w;
    wire [`PMR_DW-1:0] nv_rd;
    wire              nv_busy_w;
    wire              hard_fault;
    wire              wr_ok;
    wire              nv_wr;

    assign hard_fault = short_circuit | open_wire | internal_over_temp |
                        overvoltage_lockout | undervoltage_lockout;
    // Reserved addresses fall through every decode below untouched. [R17] [R4]
    assign wr_ok = wr_stb && !is_reserved(addr);
    // Array writes go through only while the select bit stands. [R10] [R11]
    assign nv_wr = wr_ok && is_nv(addr) && nv_sel_q && !nv_busy_w;

    pmr_nv_array u_nv (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .rd_addr     (addr[`PMR_NV_IDX_W-1:0]),
        .rd_data     (nv_rd),
        .byte_we     (nv_wr),
        .byte_addr   (addr[`PMR_NV_IDX_W-1:0]),
        .byte_data   (wr_data),
        .page_commit (nv_wr && wr_last),
        .busy_q      (nv_busy_w)
    );

    pmr_fet_ctrl u_fet (
        .ref_clk              (ref_clk),
        .reset                (reset),
        .host_switch_override (override_q),
        .host_req             (host_fet_q),
        .auto_req             (auto_req),
        .hard_fault           (hard_fault),
        .sleep_flag           (sleep_q),
        .all_switches_off     (all_switches_off),
        .drive_q              (drive_w)
    );

    // ********************************************************
    // Shadow copy of the configuration area
    // ********************************************************
    // Shadow holds no reset, so power-up contents are undefined until loaded.
    always @(posedge ref_clk) begin
        if (wr_ok && is_nv(addr) && !nv_sel_q)
            shadow_q[addr[`PMR_NV_IDX_W-1:0]] <= wr_data;  // [R9]
    end

    // ********************************************************
    // Control registers
    // ********************************************************
    always @(posedge ref_clk) begin
        if (reset) begin
            host_fet_q <= 2'h0;
            override_q <= 1'b0;
            scan_off_q <= 1'b0;
            wd_ctl_q   <= 1'b0;
            nv_sel_q   <= 1'b0;
        end else begin
            if (wr_ok && (addr == `PMR_ADDR_FETCTL))
                host_fet_q <= wr_data[`PMR_FET_CHG:`PMR_FET_DSG];  // [R1] [R8]
            if (wr_ok && (addr == `PMR_ADDR_CTL)) begin
                override_q <= wr_data[`PMR_CTL_OVR];      // [R1]
                scan_off_q <= wr_data[`PMR_CTL_SCANOFF];  // [R1]
            end
            if (wr_ok && (addr == `PMR_ADDR_NVEN))
                nv_sel_q <= wr_data[`PMR_NVEN_SEL];  // [R1]
            // Expiry wins over a host write in the same cycle. [R12]
            if (watchdog_active && watchdog_expired)
                wd_ctl_q <= 1'b0;
            else if (wr_ok && (addr == `PMR_ADDR_CTL))
                wd_ctl_q <= wr_data[`PMR_CTL_WDCTL];  // [R1]
        end
    end

    // ********************************************************
    // Sleep flag and monitor pin edges
    // ********************************************************
    always @(posedge ref_clk) begin
        if (reset) begin
            sleep_q   <= 1'b0;
            chg_mon_q <= 1'b0;
            ld_mon_q  <= 1'b1;
            pwr_up_q  <= 1'b1;
        end else begin
            chg_mon_q <= charger_monitor_input;
            ld_mon_q  <= load_monitor_input;
            pwr_up_q  <= 1'b0;
            // Wake events beat a sleep entry so the pack never misses a wake.
            if (pwr_up_q || (charger_monitor_input && !chg_mon_q) ||
                (!load_monitor_input && ld_mon_q))
                sleep_q <= 1'b0;  // [R6]
            else if (sleep_entry)
                sleep_q <= 1'b1;
        end
    end

    // ********************************************************
    // Outputs, conversion capture and read mux
    // ********************************************************
    always @(posedge ref_clk) begin
        if (reset) begin
            switch_drive_q <= 2'h0;
            scan_enable_q  <= 1'b1;
            nv_busy_q      <= 1'b0;
            adc_q          <= 14'h0000;
        end else begin
            switch_drive_q <= drive_w;
            scan_enable_q  <= !scan_off_q;  // [R14]
            nv_busy_q      <= nv_busy_w;
            if (conversion_valid)
                adc_q <= conversion_value;
        end
    end

    always @* begin
        rd_d = `PMR_RST_ZERO;
        if (is_nv(addr))
            rd_d = nv_sel_q ? nv_rd : shadow_q[addr[`PMR_NV_IDX_W-1:0]];  // [R9] [R10]
        else begin
            case (addr)
                `PMR_ADDR_STATUS: begin
                    rd_d[`PMR_ST_SLEEP] = sleep_q;           // [R2]
                    rd_d[`PMR_ST_FAULT] = hard_fault;        // [R2]
                    rd_d[`PMR_ST_OFF]   = all_switches_off;  // [R2]
                end
                `PMR_ADDR_FETCTL: rd_d = {6'h00, switch_drive_q};  // [R8]
                `PMR_ADDR_CTL:
                    rd_d = {5'h00, wd_ctl_q, scan_off_q, override_q};
                `PMR_ADDR_NVEN:   rd_d = {7'h00, nv_sel_q};
                `PMR_ADDR_ADC_LO: rd_d = adc_q[7:0];
                `PMR_ADDR_ADC_HI: rd_d = {2'h0, adc_q[13:8]} & `PMR_ADC_HI_MASK;
                default:          rd_d = `PMR_RST_ZERO;
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (reset)
            rd_data_q <= `PMR_RST_ZERO;
        else if (rd_stb)
            rd_data_q <= rd_d;
    end
endmodule

// ==== verification/pmr_regs_monitor.sv ====
/* Port checker for the pack monitor register bank.
   Assumes it is bound to pmr_regs and that the host keeps the strobe contract. */
`timescale 1ns/1ps
module pmr_regs_monitor (
    input wire       ref_clk,
    input wire       reset,
    input wire       wr_stb,
    input wire       rd_stb,
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    input wire [7:0] rd_data_q,
    input wire       charger_monitor_input,
    input wire       load_monitor_input,
    input wire       sleep_entry,
    input wire [1:0] auto_req,
    input wire       short_circuit,
    input wire       open_wire,
    input wire       internal_over_temp,
    input wire       overvoltage_lockout,
    input wire       undervoltage_lockout,
    input wire       all_switches_off,
    input wire       watchdog_expired,
    input wire       watchdog_active,
    input wire [1:0] switch_drive_q,
    input wire       scan_enable_q,
    input wire       wd_ctl_q
);
    reg  ovr_q, slp_q, chg_q, ld_q;
    wire hard = short_circuit | open_wire | internal_over_temp | overvoltage_lockout
              | undervoltage_lockout;
    wire off  = hard | all_switches_off;
    wire ok   = !off && !slp_q && !sleep_entry;
    wire wdx  = watchdog_expired && watchdog_active;
    wire idle = !wr_stb && !wdx;
    wire rsv  = (addr >= 8'h4C && addr <= 8'h4F) || (addr >= 8'h58 && addr <= 8'h7F)
              || addr >= 8'hAC;
    // Shadow of the override and sleep state, so drive checks know which mode holds.
    always @(posedge ref_clk) begin
        chg_q <= charger_monitor_input;
        ld_q  <= load_monitor_input;
        if (reset) begin
            ovr_q <= 1'b0;
            slp_q <= 1'b0;
        end else begin
            if (wr_stb && addr == 8'h88)
                ovr_q <= wr_data[0];
            if ((charger_monitor_input && !chg_q) || (!load_monitor_input && ld_q))
                slp_q <= 1'b0;
            else if (sleep_entry)
                slp_q <= 1'b1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_fault_off;
        off [*3] |-> switch_drive_q == 2'h0;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("switch drive on during fault");
    property p_auto;
        (!ovr_q && ok && $stable(auto_req)) [*4] |-> switch_drive_q == auto_req;
    endproperty
    a_auto: assert property (p_auto)
        else $error("automatic drive does not follow request");
    property p_host;
        (wr_stb && addr == 8'h86 && ovr_q && ok) ##1 (ok && !wr_stb) [*2]
            |=> switch_drive_q == $past(wr_data[1:0], 3);
    endproperty
    a_host: assert property (p_host)
        else $error("host write did not reach switch drive");
    property p_read_drive;
        (rd_stb && addr == 8'h86) ##1 $stable(switch_drive_q)
            |-> rd_data_q == {6'h00, switch_drive_q};
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("switch register read differs from drive");
    property p_scan;
        (wr_stb && addr == 8'h88) ##1 (!wr_stb) [*2] |-> scan_enable_q == !$past(wr_data[1], 2);
    endproperty
    a_scan: assert property (p_scan)
        else $error("scan enable does not follow control write");
    property p_wd_clear;
        wdx |-> ##[1:2] !wd_ctl_q;
    endproperty
    a_wd_clear: assert property (p_wd_clear)
        else $error("watchdog bit not cleared on expiry");
    property p_rsv;
        idle ##1 (wr_stb && rsv && !wdx) ##1 idle [*2]
            |-> $stable(scan_enable_q) && (wd_ctl_q == $past(wd_ctl_q, 2));
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved write changed control state");
    property p_status;
        hard [*3] ##1 (hard && rd_stb && addr == 8'h80) |=> rd_data_q[1] && rd_data_q[7:3] == 5'h00;
    endproperty
    a_status: assert property (p_status)
        else $error("fault status bit not read as one");
endmodule

bind pmr_regs pmr_regs_monitor u_mon (.ref_clk(ref_clk), .reset(reset), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .addr(addr), .wr_data(wr_data), .rd_data_q(rd_data_q),
    .charger_monitor_input(charger_monitor_input), .load_monitor_input(load_monitor_input),
    .sleep_entry(sleep_entry), .auto_req(auto_req), .short_circuit(short_circuit),
    .open_wire(open_wire), .internal_over_temp(internal_over_temp),
    .overvoltage_lockout(overvoltage_lockout), .undervoltage_lockout(undervoltage_lockout),
    .all_switches_off(all_switches_off), .watchdog_expired(watchdog_expired),
    .watchdog_active(watchdog_active), .switch_drive_q(switch_drive_q),
    .scan_enable_q(scan_enable_q), .wd_ctl_q(wd_ctl_q));

// ==== verification/pmr_host_model.sv ====
/* Host controller model issuing one-cycle register strobes.
   Assumes read data is loaded at the edge that takes the read strobe. */
`timescale 1ns/1ps
module pmr_host_model (
    input  wire       ref_clk,
    input  wire [7:0] rd_data_q,
    output reg        wr_stb,
    output reg        rd_stb,
    output reg  [7:0] addr,
    output reg  [7:0] wr_data,
    output reg        wr_last
);
    initial begin
        wr_stb  = 1'b0;
        rd_stb  = 1'b0;
        addr    = 8'h00;
        wr_data = 8'h00;
        wr_last = 1'b0;
    end
    // Released address and data lines are inverted, strobes dropped to zero, so that a late sample never sees the old value.
    task wr(input [7:0] a, input [7:0] d, input l);
        begin
            @(posedge ref_clk);
            #1;
            wr_stb  = 1'b1;
            addr    = a;
            wr_data = d;
            wr_last = l;
            @(posedge ref_clk);
            #1;
            wr_stb  = 1'b0;
            addr    = ~a;
            wr_data = ~d;
            wr_last = 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge ref_clk);
            #1;
            rd_stb = 1'b1;
            addr   = a;
            @(posedge ref_clk);
            #1;
            d      = rd_data_q;
            rd_stb = 1'b0;
            addr   = ~a;
        end
    endtask
endmodule

// ==== verification/pmr_regs_tb.sv ====
/* Self-checking bench for the pack monitor register bank.
   Assumes the host model and the bound port checker are compiled with it. */
`timescale 1ns/1ps
module pmr_regs_tb;
    localparam [31:0] RSV = 32'h4C7FACFF;
    reg          ref_clk, reset, chg, ld, slp, wde, wda, cvld;
    reg  [5:0]   flt;
    reg  [1:0]   auto;
    reg  [13:0]  cv;
    reg  [7:0]   v, d;
    reg  [7:0]   pg [0:15];
    integer      seed, r, i, j, bad_count, check_count;
    wire         wr_stb, rd_stb, wr_last, nv_busy_q, scan_enable_q, wd_ctl_q;
    wire [7:0]   addr, wr_data, rd_data_q;
    wire [1:0]   switch_drive_q;

    pmr_host_model host (.ref_clk(ref_clk), .rd_data_q(rd_data_q), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .addr(addr), .wr_data(wr_data), .wr_last(wr_last));
    pmr_regs dut (.ref_clk(ref_clk), .reset(reset), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .addr(addr), .wr_data(wr_data), .wr_last(wr_last), .rd_data_q(rd_data_q),
        .nv_busy_q(nv_busy_q), .charger_monitor_input(chg), .load_monitor_input(ld),
        .sleep_entry(slp), .auto_req(auto), .short_circuit(flt[0]), .open_wire(flt[1]),
        .internal_over_temp(flt[2]), .overvoltage_lockout(flt[3]),
        .undervoltage_lockout(flt[4]), .all_switches_off(flt[5]), .watchdog_expired(wde),
        .watchdog_active(wda), .conversion_value(cv), .conversion_valid(cvld),
        .switch_drive_q(switch_drive_q), .scan_enable_q(scan_enable_q), .wd_ctl_q(wd_ctl_q));

    always #4 ref_clk = ~ref_clk;

    function [7:0] st_exp(input integer k);
        st_exp = (k < 5) ? 8'h02 : 8'h04;
    endfunction
    task stop_test;
        begin
            if (bad_count == 0 && check_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                $display("unexpected %s expected %h seen %h", nm, e, g);
                bad_count = bad_count + 1;
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge ref_clk);
            #1;
        end
    endtask
    task rdc(input [7:0] a, input [7:0] e);
        begin
            host.rd(a, v);
            chk($sformatf("reg %h", a), e, v);
        end
    endtask

    initial begin
        #100000;
        bad_count = bad_count + 1;
        stop_test;
    end
    initial begin
        {ref_clk, chg, slp, wde, wda, cvld, flt, auto, cv} = 0;
        reset = 1'b1;
        ld = 1'b1;
        seed = 3242;
        bad_count = 0;
        check_count = 0;
        tick(16);
        reset = 1'b0;
        rdc(8'h86, 8'h00);
        rdc(8'h80, 8'h00);
        host.wr(8'h88, 8'h06, 1'b0);
        tick(2);
        rdc(8'h88, 8'h06);
        chk("scan", 8'h00, {7'h00, scan_enable_q});
        chk("wd", 8'h01, {7'h00, wd_ctl_q});
        {wde, wda} = 2'h3;
        tick(1);
        {wde, wda} = 2'h0;
        tick(2);
        chk("wd", 8'h00, {7'h00, wd_ctl_q});
        rdc(8'h88, 8'h02);
        host.wr(8'h88, 8'h00, 1'b0);
        for (i = 0; i < 8; i = i + 1) begin
            r = $random(seed);
            auto = r[1:0];
            tick(4);
            chk("auto", {6'h00, auto}, {6'h00, switch_drive_q});
        end
        rdc(8'h86, {6'h00, auto});
        host.wr(8'h88, 8'h03, 1'b0);
        for (i = 0; i < 5; i = i + 1) begin
            r = $random(seed);
            auto = r[3:2];
            d = (i == 4) ? 8'h03 : {6'h00, r[1:0]};
            host.wr(8'h86, d, 1'b0);
            tick(3);
            chk("host", d, {6'h00, switch_drive_q});
            rdc(8'h86, d);
        end
        for (i = 0; i < 6; i = i + 1) begin
            flt = 6'h01 << i;
            tick(3);
            chk("fault", 8'h00, {6'h00, switch_drive_q});
            rdc(8'h80, st_exp(i));
            flt = 6'h00;
            tick(3);
            chk("back", 8'h03, {6'h00, switch_drive_q});
        end
        slp = 1'b1;
        tick(1);
        slp = 1'b0;
        tick(3);
        chk("sleep", 8'h00, {6'h00, switch_drive_q});
        rdc(8'h80, 8'h01);
        chg = 1'b1;
        tick(2);
        rdc(8'h80, 8'h00);
        slp = 1'b1;
        tick(1);
        slp = 1'b0;
        ld = 1'b0;
        tick(2);
        rdc(8'h80, 8'h00);
        r = $random(seed);
        cv = r[13:0];
        cvld = 1'b1;
        tick(1);
        cvld = 1'b0;
        rdc(8'hAA, cv[7:0]);
        rdc(8'hAB, {2'h0, cv[13:8]});
        host.wr(8'h89, 8'h00, 1'b0);
        host.wr(8'h10, 8'hA5, 1'b0);
        host.wr(8'h89, 8'h01, 1'b0);
        for (i = 0; i < 16; i = i + 1) begin
            r = $random(seed);
            pg[i] = r[7:0];
            host.wr(8'h20 + i[7:0], pg[i], i == 15);
        end
        tick(1);
        chk("busy", 8'h01, {7'h00, nv_busy_q});
        host.wr(8'h20, ~pg[0], 1'b1);
        for (j = 0; j < 2000 && nv_busy_q !== 1'b0; j = j + 1)
            tick(1);
        chk("busy", 8'h00, {7'h00, nv_busy_q});
        for (i = 0; i < 16; i = i + 1)
            rdc(8'h20 + i[7:0], pg[i]);
        host.wr(8'h89, 8'h00, 1'b0);
        rdc(8'h10, 8'hA5);
        for (i = 0; i < 4; i = i + 1) begin
            host.wr(RSV[31-8*i -: 8], 8'h07, 1'b0);
            tick(1);
        end
        rdc(8'h88, 8'h03);
        rdc(8'h10, 8'hA5);
        stop_test;
    end
endmodule
